// *** hw/lcd_cfg_pkg.sv ***
package lcd_cfg_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int IDX_W = 14;

    // ==========================================================
    // Register indexes (byte address is four times the index)
    localparam logic [13:0] IDX_BOOT = 14'h00b2;
    localparam logic [13:0] IDX_MUX_CNT = 14'h2002;
    localparam logic [13:0] IDX_CPU_DIV = 14'h2004;
    localparam logic [13:0] IDX_MUX_CTL = 14'h2005;
    localparam logic [13:0] IDX_OPT = 14'h2008;
    localparam logic [13:0] IDX_SPLIT = 14'h2020;
    localparam logic [13:0] IDX_DISP = 14'h2021;
    localparam logic [13:0] IDX_SEG_FIRST = 14'h2030;
    localparam logic [13:0] IDX_SEG_LAST = 14'h2059;
    localparam logic [13:0] IDX_SERIAL = 14'h2070;

    // ==========================================================
    // Field positions
    localparam int MUX_CNT_LSB = 6;
    localparam int SYNC_EN_BIT = 0;
    localparam int ALT_BIT = 2;
    localparam int OPT_BIT = 5;
    localparam int DISP_BIT = 5;
    localparam int SERIAL_BIT = 7;
    localparam int BOOT_BIT = 7;

    // ==========================================================
    // Sizes and limits
    localparam int SEG_COUNT = 42;
    localparam int SEG_W = 4;
    localparam int SHARED_PINS = 18;
    localparam logic [4:0] SPLIT_MAX = 5'h12;
    localparam int DIV_CNT_W = 7;

    // ==========================================================
    // Values after reset
    localparam logic [1:0] RST_MUX_CNT = 2'h0;
    localparam logic [2:0] RST_CPU_DIV = 3'h0;
    localparam logic [4:0] RST_SPLIT = 5'h00;
    localparam logic [3:0] RST_SEG = 4'h0;
    localparam logic RST_FLAG = 1'b0;

    // ==========================================================
    // Multiplexer state counts per code
    localparam logic [2:0] MUX_STATES_00 = 3'h6;
    localparam logic [2:0] MUX_STATES_01 = 3'h4;
    localparam logic [2:0] MUX_STATES_10 = 3'h3;
    localparam logic [2:0] MUX_STATES_11 = 3'h2;

endpackage

// *** hw/cpu_div_if.sv ***
`timescale 1ns/1ps

// Divider code out to the clock divider, tick back
interface cpu_div_if;
    logic [2:0] code;
    logic tick;
    modport ctrl (output code, input tick);
    modport div (input code, output tick);
endinterface

// *** hw/cpu_clock_divider.sv ***
`timescale 1ns/1ps

module cpu_clock_divider #(
    parameter int CNT_W = lcd_cfg_pkg::DIV_CNT_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    cpu_div_if.div bus
);
    import lcd_cfg_pkg::*;

    // ==========================================================
    // Divide by two to the power of the active code
    logic [2:0] code_q;
    logic [CNT_W-1:0] cnt_q;
    logic tick_q;
    logic [CNT_W-1:0] mask;
    logic wrap;

    // Count mask and end of period
    assign mask = ~({CNT_W{1'b1}} << code_q);
    assign wrap = (cnt_q == mask);
    assign bus.tick = tick_q;

    // New code taken only at a period end, no short period
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            code_q <= RST_CPU_DIV;
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= wrap;
            if (wrap) begin
                code_q <= bus.code;
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule

// *** hw/lcd_pin_and_clock_config_bank.sv ***
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - Pin-split field is five bits and holds values 0 to 18.
// - Split N gives the top N shared pins to segments, rest to I/O.
// - Forty-two four-bit display words, bit k drives backplane line k.
// - Processor clock comes from engine clock through a 3-bit divider, safe to change.
// - Divider code 000 passes the clock, 001 halves it, up to 111.
// - Alternate-input bit moves the input selector to its alternate inputs.
// - Sync-output enable turns segment pin 7 into the selector sync output.
// - Read-only flag reads one while the preboot sequence runs.
// - Serial enable with display off hands its pins to the serial interface.
module lcd_pin_and_clock_config_bank #(
    parameter int SEGS = lcd_cfg_pkg::SEG_COUNT,
    parameter int SHARED = lcd_cfg_pkg::SHARED_PINS
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [lcd_cfg_pkg::ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [lcd_cfg_pkg::DATA_W-1:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [lcd_cfg_pkg::DATA_W-1:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_PREBOOT,
    output logic O_CPU_CLK_EN,
    output logic [2:0] O_MUX_STATES,
    output logic O_ALTERNATE_INPUT_SELECT,
    output logic O_SEG7_SYNC_SEL,
    output logic O_OPT_TX_DIS,
    output logic [SHARED-1:0] O_SHARED_IS_SEG,
    output logic [SHARED-1:0] O_SHARED_IS_IO,
    output logic O_SERIAL_PINS,
    output logic [SEGS*lcd_cfg_pkg::SEG_W-1:0] O_SEG_DATA
);
    import lcd_cfg_pkg::*;

    // ==========================================================
    // Decode helpers

    // True when the word index names the given register
    function automatic logic is_idx(
        input logic [IDX_W-1:0] idx,
        input logic [IDX_W-1:0] reg_idx
    );
        is_idx = (idx == reg_idx);
    endfunction

    // True when the word index falls in the display words
    function automatic logic in_seg(input logic [IDX_W-1:0] idx);
        in_seg = (idx >= IDX_SEG_FIRST) && (idx <= IDX_SEG_LAST);
    endfunction

    // ==========================================================
    // Bus handshake state
    logic wait_q;
    logic [DATA_W-1:0] rdata_q;

    // ==========================================================
    // Register state
    logic [1:0] mux_cnt_q;
    logic [2:0] cpu_div_q;
    logic alt_q;
    logic sync_en_q;
    logic opt_q;
    logic [4:0] split_q;
    logic disp_q;
    logic serial_q;
    logic [SEG_W-1:0] seg_q [SEGS];

    // ==========================================================
    // Preboot synchroniser
    logic boot_meta_q;
    logic boot_q;

    // ==========================================================
    // Output flops
    logic cpu_en_q;
    logic [2:0] mux_states_q;
    logic [SHARED-1:0] is_seg_q;
    logic serial_pins_q;
    logic [SHARED-1:0] is_io_q;

    // ==========================================================
    // Bus decode wires
    logic [IDX_W-1:0] idx;
    logic req;
    logic take;
    logic wr_go;
    logic hit_mux_cnt;
    logic hit_cpu_div;
    logic hit_mux_ctl;
    logic hit_opt;
    logic hit_split;
    logic hit_disp;
    logic hit_serial;
    logic hit_boot;
    logic hit_seg;
    logic [IDX_W-1:0] seg_off;
    logic [5:0] seg_ptr;
    logic [4:0] split_wr;
    logic [DATA_W-1:0] rd_word;

    // ==========================================================
    // Read words, one per register
    logic [DATA_W-1:0] rw_mux_cnt;
    logic [DATA_W-1:0] rw_cpu_div;
    logic [DATA_W-1:0] rw_mux_ctl;
    logic [DATA_W-1:0] rw_opt;
    logic [DATA_W-1:0] rw_split;
    logic [DATA_W-1:0] rw_disp;
    logic [DATA_W-1:0] rw_serial;
    logic [DATA_W-1:0] rw_boot;
    logic [DATA_W-1:0] rw_seg;

    // ==========================================================
    // Write data fields
    logic [1:0] wf_mux_cnt;
    logic [2:0] wf_cpu_div;
    logic wf_alt;
    logic wf_sync;
    logic wf_opt;
    logic wf_disp;
    logic wf_serial;
    logic [SEG_W-1:0] wf_seg;

    // ==========================================================
    // Derived control wires
    logic [2:0] mux_states_d;
    logic [SHARED-1:0] is_seg_d;
    logic serial_pins_d;

    // Divider link to the clock divider
    cpu_div_if div_bus ();

    // ==========================================================
    // Address decode
    assign idx = I_AVS_ADDRESS[ADDR_W-1:2];
    assign req = I_AVS_READ | I_AVS_WRITE;
    assign hit_mux_cnt = is_idx(idx, IDX_MUX_CNT);
    assign hit_cpu_div = is_idx(idx, IDX_CPU_DIV);
    assign hit_mux_ctl = is_idx(idx, IDX_MUX_CTL);
    assign hit_opt = is_idx(idx, IDX_OPT);
    assign hit_split = is_idx(idx, IDX_SPLIT);
    assign hit_disp = is_idx(idx, IDX_DISP);
    assign hit_serial = is_idx(idx, IDX_SERIAL);
    assign hit_boot = is_idx(idx, IDX_BOOT);
    assign hit_seg = in_seg(idx);
    assign seg_off = idx - IDX_SEG_FIRST;
    assign seg_ptr = seg_off[5:0];

    // Request sampled while wait is high, committed when wait is low
    assign take = req & wait_q;
    assign wr_go = I_AVS_WRITE & ~wait_q & I_AVS_BYTEENABLE[0];

    // Split writes above the top value saturate
    assign split_wr = (I_AVS_WRITEDATA[4:0] > SPLIT_MAX) ? SPLIT_MAX
                    : I_AVS_WRITEDATA[4:0];

    // Write data fields, all in the low byte
    assign wf_mux_cnt = I_AVS_WRITEDATA[MUX_CNT_LSB+:2];
    assign wf_cpu_div = I_AVS_WRITEDATA[2:0];
    assign wf_alt = I_AVS_WRITEDATA[ALT_BIT];
    assign wf_sync = I_AVS_WRITEDATA[SYNC_EN_BIT];
    assign wf_opt = I_AVS_WRITEDATA[OPT_BIT];
    assign wf_disp = I_AVS_WRITEDATA[DISP_BIT];
    assign wf_serial = I_AVS_WRITEDATA[SERIAL_BIT];
    assign wf_seg = I_AVS_WRITEDATA[SEG_W-1:0];

    // ==========================================================
    // Read words, each field at its bit position
    assign rw_mux_cnt = {24'h0000_00, mux_cnt_q, 6'h00};
    assign rw_cpu_div = {29'h0000_0000, cpu_div_q};
    assign rw_mux_ctl = {29'h0000_0000, alt_q, 1'b0, sync_en_q};
    assign rw_opt = {26'h000_0000, opt_q, 5'h00};
    assign rw_split = {27'h000_0000, split_q};
    assign rw_disp = {26'h000_0000, disp_q, 5'h00};
    assign rw_serial = {24'h0000_00, serial_q, 7'h00};
    assign rw_boot = {24'h0000_00, boot_q, 7'h00};
    assign rw_seg = {28'h000_0000, seg_q[seg_ptr]};

    // Read selection, unmapped words read zero
    assign rd_word =
        hit_mux_cnt ? rw_mux_cnt :
        hit_cpu_div ? rw_cpu_div :
        hit_mux_ctl ? rw_mux_ctl :
        hit_opt ? rw_opt :
        hit_split ? rw_split :
        hit_disp ? rw_disp :
        hit_serial ? rw_serial :
        hit_boot ? rw_boot :
        hit_seg ? rw_seg :
        32'h0000_0000;

    // ==========================================================
    // Bus handshake: one wait cycle, then one ready cycle
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~take;
            if (take && I_AVS_READ) begin
                rdata_q <= rd_word;
            end
        end
    end

    assign O_AVS_WAITREQUEST = wait_q;
    assign O_AVS_READDATA = rdata_q;

    // ==========================================================
    // Selector, clock and optical control registers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            mux_cnt_q <= RST_MUX_CNT;
            cpu_div_q <= RST_CPU_DIV;
            alt_q <= RST_FLAG;
            sync_en_q <= RST_FLAG;
            opt_q <= RST_FLAG;
        end else if (wr_go) begin
            if (hit_mux_cnt) begin
                mux_cnt_q <= wf_mux_cnt;
            end
            if (hit_cpu_div) begin
                cpu_div_q <= wf_cpu_div;
            end
            if (hit_mux_ctl) begin
                alt_q <= wf_alt;
                sync_en_q <= wf_sync;
            end
            if (hit_opt) begin
                opt_q <= wf_opt;
            end
        end
    end

    // ==========================================================
    // Pin assignment registers
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            split_q <= RST_SPLIT;
            disp_q <= RST_FLAG;
            serial_q <= RST_FLAG;
        end else if (wr_go) begin
            if (hit_split) begin
                split_q <= split_wr;
            end
            if (hit_disp) begin
                disp_q <= wf_disp;
            end
            if (hit_serial) begin
                serial_q <= wf_serial;
            end
        end
    end

    // ==========================================================
    // Display words, one register per segment
    genvar g;
    generate
        for (g = 0; g < SEGS; g++) begin : g_seg
            // Word write for this segment
            always_ff @(posedge I_CLK or posedge I_RST) begin
                if (I_RST) begin
                    seg_q[g] <= RST_SEG;
                end else if (wr_go && hit_seg && (seg_ptr == 6'(g))) begin
                    seg_q[g] <= wf_seg;
                end
            end

            // Bit k of the word feeds backplane line k
            assign O_SEG_DATA[g*SEG_W+:SEG_W] = seg_q[g];
        end
    endgenerate

    // ==========================================================
    // Preboot flag, two flops from the pin
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            boot_meta_q <= 1'b0;
            boot_q <= 1'b0;
        end else begin
            boot_meta_q <= I_PREBOOT;
            boot_q <= boot_meta_q;
        end
    end

    // ==========================================================
    // Shared pin split: pair i is segment 24+i or I/O 4+i
    generate
        for (g = 0; g < SHARED; g++) begin : g_pin
            // Top N pairs go to the display
            assign is_seg_d[g] = (32'(split_q) + 32'(g)) >= 32'(SHARED);
        end
    endgenerate

    // Serial takeover of its own pins while the display is off
    assign serial_pins_d = serial_q & ~disp_q;

    // ==========================================================
    // Selector state count decode
    assign mux_states_d =
        (mux_cnt_q == 2'h0) ? MUX_STATES_00 :
        (mux_cnt_q == 2'h1) ? MUX_STATES_01 :
        (mux_cnt_q == 2'h2) ? MUX_STATES_10 :
        MUX_STATES_11;

    // ==========================================================
    // Processor clock divider
    assign div_bus.code = cpu_div_q;

    cpu_clock_divider #(
        .CNT_W(DIV_CNT_W)
    ) u_cpu_div (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .bus(div_bus)
    );

    // ==========================================================
    // Registered pin and control outputs
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            cpu_en_q <= 1'b0;
            mux_states_q <= MUX_STATES_00;
            is_seg_q <= '0;
            is_io_q <= '1;
            serial_pins_q <= 1'b0;
        end else begin
            cpu_en_q <= div_bus.tick;
            mux_states_q <= mux_states_d;
            is_seg_q <= is_seg_d;
            is_io_q <= ~is_seg_d;
            serial_pins_q <= serial_pins_d;
        end
    end

    // Outputs straight from the flops
    assign O_CPU_CLK_EN = cpu_en_q;
    assign O_MUX_STATES = mux_states_q;
    assign O_ALTERNATE_INPUT_SELECT = alt_q;
    assign O_SEG7_SYNC_SEL = sync_en_q;
    assign O_OPT_TX_DIS = opt_q;
    assign O_SHARED_IS_SEG = is_seg_q;
    assign O_SHARED_IS_IO = is_io_q;
    assign O_SERIAL_PINS = serial_pins_q;

endmodule

// *** tb/lcd_bank_monitor.sv ***
`timescale 1ns/1ps

// ==========================================
// Bus answer, pin split, divider and selector checks
module lcd_bank_monitor #(
    parameter int SHARED = lcd_cfg_pkg::SHARED_PINS
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic [15:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire logic O_AVS_WAITREQUEST,
    input wire logic O_CPU_CLK_EN,
    input wire logic [2:0] O_MUX_STATES,
    input wire logic O_ALTERNATE_INPUT_SELECT,
    input wire logic O_SEG7_SYNC_SEL,
    input wire logic [SHARED-1:0] O_SHARED_IS_SEG,
    input wire logic [SHARED-1:0] O_SHARED_IS_IO
);
    import lcd_cfg_pkg::*;
    // Write decode and expected values
    wire [13:0] ix = I_AVS_ADDRESS[15:2];
    wire wr_go = I_AVS_WRITE && !O_AVS_WAITREQUEST;
    wire [31:0] d = I_AVS_WRITEDATA;
    wire [2:0] want_st = d[7] ? (d[6] ? 3'h2 : 3'h3) : (d[6] ? 3'h4 : 3'h6);
    wire [4:0] want_n = (d[4:0] > 5'h12) ? 5'h12 : d[4:0];
    wire is_div = wr_go && I_AVS_BYTEENABLE[0] && ix == IDX_CPU_DIV;
    logic [2:0] code_q;
    logic [7:0] gap_q;
    logic [8:0] since_q;

    // Divider code, cycles since last enable, cycles since a code change
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            code_q <= 3'h0;
            gap_q <= 8'h00;
            since_q <= 9'h000;
        end else begin
            code_q <= is_div ? d[2:0] : code_q;
            gap_q <= O_CPU_CLK_EN ? 8'h00 : gap_q + 8'h01;
            since_q <= is_div ? 9'h000 : since_q + {8'h00, ~&since_q};
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    // Steps of a write commit and of a bus answer
    sequence s_commit(r, b);
        wr_go && I_AVS_BYTEENABLE[0] == b && ix == r;
    endsequence
    sequence s_answer;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence

    // ==========================================
    // Assertions
    AST_WAIT_ONE: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> s_answer)
        else $error("bus answer not one cycle");
    AST_IO_INVERSE: assert property (O_SHARED_IS_IO == ~O_SHARED_IS_SEG)
        else $error("pin both or neither");
    AST_SEG_FROM_TOP: assert property (((O_SHARED_IS_IO + SHARED'(1)) & O_SHARED_IS_IO) == '0)
        else $error("segment pins not from top");
    AST_SPLIT_COUNT: assert property (s_commit(IDX_SPLIT, 1'b1) |-> ##2
        $countones(O_SHARED_IS_SEG) == $past(want_n, 2)) else $error("segment count wrong");
    AST_DIV_PERIOD: assert property (since_q > 9'h12c |->
        O_CPU_CLK_EN == (gap_q == (8'h01 << code_q) - 8'h01)) else $error("enable period wrong");
    AST_ALT_SET: assert property (s_commit(IDX_MUX_CTL, 1'b1) |=>
        O_ALTERNATE_INPUT_SELECT == $past(d[ALT_BIT])) else $error("alternate select wrong");
    AST_SYNC_SET: assert property (s_commit(IDX_MUX_CTL, 1'b1) |=>
        O_SEG7_SYNC_SEL == $past(d[SYNC_EN_BIT])) else $error("sync select wrong");
    AST_STATES: assert property (s_commit(IDX_MUX_CNT, 1'b1) |-> ##2
        O_MUX_STATES == $past(want_st, 2)) else $error("state count wrong");
    AST_BYTE_GATE: assert property (s_commit(IDX_MUX_CTL, 1'b0) |=>
        $stable(O_ALTERNATE_INPUT_SELECT) && $stable(O_SEG7_SYNC_SEL)) else $error("gated write applied");
endmodule

bind lcd_pin_and_clock_config_bank lcd_bank_monitor #(.SHARED(SHARED)) u_monitor (
    .I_CLK, .I_RST, .I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .I_AVS_WRITEDATA,
    .I_AVS_BYTEENABLE, .O_AVS_WAITREQUEST, .O_CPU_CLK_EN, .O_MUX_STATES, .O_ALTERNATE_INPUT_SELECT,
    .O_SEG7_SYNC_SEL, .O_SHARED_IS_SEG, .O_SHARED_IS_IO
);

// *** tb/lcd_pin_and_clock_config_bank_bench.sv ***
`timescale 1ns/1ps

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s: expected %0h, seen %0h", nm, e, g); end end

// ==========================================
// Self-checking bench for the configuration bank
module lcd_pin_and_clock_config_bank_bench;
    import lcd_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic pre = 1'b0;
    logic [3:0] be = 4'h0;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] q;
    logic [31:0] r;
    logic [3:0] word [SEG_COUNT];
    logic [13:0] rw_regs [7] = '{IDX_MUX_CNT, IDX_CPU_DIV, IDX_MUX_CTL, IDX_OPT, IDX_SPLIT,
        IDX_SEG_FIRST, IDX_SEG_LAST};
    wire [31:0] rdata;
    wire wait_r, clk_en, alt, sync, opt, serial;
    wire [2:0] states;
    wire [17:0] is_seg, is_io;
    wire [167:0] seg_data;
    int err_total = 0;
    int checks = 0;
    int seed = 32'hdea4_8183;
    int n;
    int p;

    lcd_pin_and_clock_config_bank u_dut (
        .I_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
        .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(wait_r), .I_PREBOOT(pre), .O_CPU_CLK_EN(clk_en),
        .O_MUX_STATES(states), .O_ALTERNATE_INPUT_SELECT(alt), .O_SEG7_SYNC_SEL(sync), .O_OPT_TX_DIS(opt),
        .O_SHARED_IS_SEG(is_seg), .O_SHARED_IS_IO(is_io), .O_SERIAL_PINS(serial),
        .O_SEG_DATA(seg_data)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // Counts and verdict
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low, then released
    task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] dv,
            input logic [3:0] b);
        int k;
        k = 0;
        wr <= w;
        rd <= ~w;
        addr <= {a, 2'b00};
        wd <= dv;
        be <= b;
        do begin
            @(posedge clk);
            k++;
        end while (wait_r !== 1'b0);
        `CHK("wait cycles", 2, k)
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    // Write, then one more edge so derived outputs settle
    task automatic wreg(input logic [13:0] a, input logic [31:0] dv);
        xfer(1'b1, a, dv, 4'h1);
        @(posedge clk);
    endtask

    task automatic rd_cmp(input string nm, input logic [13:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
        `CHK(nm, e, q)
    endtask

    // Expected segment mask: the top n shared pins
    function automatic logic [17:0] exp_seg(input int n);
        exp_seg = ~(18'h3_ffff >> n);
    endfunction

    // Expected selector state count for a code
    function automatic logic [2:0] exp_states(input int c);
        exp_states = c[1] ? 3'h3 - 3'(c[0]) : 3'h6 - 3'(2 * c[0]);
    endfunction

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end

    // Test sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        pre <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("io pins", 18'h3_ffff, is_io)
        `CHK("states", 3'h6, states)
        foreach (rw_regs[i]) begin
            rd_cmp("reset value", rw_regs[i], 32'h0000_0000);
        end
        rd_cmp("boot flag", IDX_BOOT, 32'h0000_0080);
        $display("reset test done");
        for (int v = 0; v < 32; v++) begin
            n = (v > 18) ? 18 : v;
            wreg(IDX_SPLIT, 32'(v));
            rd_cmp("split", IDX_SPLIT, 32'(n));
            `CHK("segment pins", exp_seg(n), is_seg)
            `CHK("io pins", ~exp_seg(n), is_io)
        end
        $display("split test done");
        for (int g = 0; g < SEG_COUNT; g++) begin
            r = $random(seed);
            word[g] = r[3:0];
            wreg(IDX_SEG_FIRST + 14'(g), {28'h000_0000, r[3:0]});
        end
        for (int g = 0; g < SEG_COUNT; g++) begin
            rd_cmp("display word", IDX_SEG_FIRST + 14'(g), {28'h000_0000, word[g]});
            `CHK("segment data", word[g], seg_data[4*g +: 4])
        end
        $display("display test done");
        for (int c = 7; c >= 0; c--) begin
            wreg(IDX_CPU_DIV, 32'(c));
            rd_cmp("divider", IDX_CPU_DIV, 32'(c));
            repeat (300) @(posedge clk);
            n = 0;
            while (clk_en !== 1'b1 && n < 300) begin
                @(posedge clk);
                n++;
            end
            p = 0;
            do begin
                @(posedge clk);
                p++;
            end while (clk_en !== 1'b1 && p < 300);
            `CHK("enable period", 1 << c, p)
        end
        $display("divider test done");
        for (int c = 0; c < 4; c++) begin
            r = $random(seed);
            wreg(IDX_MUX_CNT, 32'(c) << 6);
            `CHK("states", exp_states(c), states)
            wreg(IDX_MUX_CTL, r & 32'h0000_001f);
            `CHK("alternate", r[ALT_BIT], alt)
            `CHK("sync select", r[SYNC_EN_BIT], sync)
            xfer(1'b1, IDX_MUX_CTL, ~r, 4'he);
            `CHK("alternate kept", r[ALT_BIT], alt)
            wreg(IDX_OPT, r & 32'h0000_0020);
            `CHK("optical disable", r[OPT_BIT], opt)
            wreg(IDX_DISP, 32'(c[0]) << DISP_BIT);
            wreg(IDX_SERIAL, 32'(c[1]) << SERIAL_BIT);
            `CHK("serial pins", c[1] & ~c[0], serial)
        end
        $display("selector test done");
        wreg(14'h0100, 32'hffff_ffff);
        rd_cmp("unmapped", 14'h0100, 32'h0000_0000);
        pre <= 1'b0;
        wreg(IDX_BOOT, 32'h0000_0080);
        rd_cmp("boot flag", IDX_BOOT, 32'h0000_0000);
        $display("access test done");
        tally_and_finish();
    end
endmodule
